//--- iopc_defs.svh
`ifndef IOPC_DEFS_SVH
`define IOPC_DEFS_SVH
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define IOPC_BIDIR_W      16
`define IOPC_INONLY_W     8
`define IOPC_EXT_IRQ_N    4
`define IOPC_IR_BIT       15
`define IOPC_DIR_RST      16'h0000
`define IOPC_OUT_RST      16'h0000
`define IOPC_PU_BIDIR_RST 16'h0000
`define IOPC_PU_IN_RST    8'h00
// sync chain stages to refill after reset before edges count
`define IOPC_SYNC_FILL    2'h3
// ----------------------------------------
// carrier timing
// ----------------------------------------
`define IOPC_CLK_HZ       20000000
`define IOPC_CARRIER_HZ   38500
// half period in cycles, rounded down: 20e6 / (2 * 38500) = 259
`define IOPC_CAR_HALF     (`IOPC_CLK_HZ / (2 * `IOPC_CARRIER_HZ))
`define IOPC_CAR_CNT_W    9
`endif

//--- iopc_pkg.sv
package iopc_pkg;
  `include "iopc_defs.svh"
  typedef logic [`IOPC_BIDIR_W-1:0]   iopc_bidir_t;
  typedef logic [`IOPC_INONLY_W-1:0]  iopc_inonly_t;
  typedef logic [`IOPC_EXT_IRQ_N-1:0] iopc_irq_t;
  typedef enum logic [0:0] {
    IOPC_CAR_LO = 1'b0,
    IOPC_CAR_HI = 1'b1
  } iopc_car_st_t;
endpackage

//--- iopc_car_if.sv
`timescale 1ns/1ps
interface iopc_car_if;
  logic enable;
  logic carrier;
  modport gen (input enable, output carrier);
  modport use_side (output enable, input carrier);
endinterface

//--- iopc_carrier.sv
`timescale 1ns/1ps
`include "iopc_defs.svh"
module iopc_carrier (
  // clock and reset
  input  wire logic mclk,
  input  wire logic nrst,
  // carrier link
  iopc_car_if.gen   car
);
  import iopc_pkg::*;

  localparam logic [`IOPC_CAR_CNT_W-1:0] HALF_M1 = `IOPC_CAR_CNT_W'(`IOPC_CAR_HALF - 1);

  logic [`IOPC_CAR_CNT_W-1:0] cnt_r;
  logic [`IOPC_CAR_CNT_W-1:0] cnt_nxt;
  iopc_car_st_t               st_r;
  iopc_car_st_t               st_nxt;

  // free square wave, state held high while off (output low) so each burst starts in a known phase
  always_comb begin
    cnt_nxt = cnt_r;
    st_nxt  = st_r;
    if (!car.enable) begin
      cnt_nxt = '0;
      st_nxt  = IOPC_CAR_HI;
    end else if (cnt_r == HALF_M1) begin
      cnt_nxt = '0;
      unique case (st_r)
        IOPC_CAR_LO: st_nxt = IOPC_CAR_HI;
        IOPC_CAR_HI: st_nxt = IOPC_CAR_LO;
      endcase
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
      st_r  <= IOPC_CAR_HI;
    end else begin
      cnt_r <= cnt_nxt;
      st_r  <= st_nxt;
    end
  end

  assign car.carrier = car.enable && (st_r == IOPC_CAR_HI);

  // toggles exactly every half period while enabled
  car_period_a: assert property (@(posedge mclk) disable iff (!nrst)
    (car.enable && cnt_r == HALF_M1) ##1 car.enable |-> st_r != $past(st_r))
    else $error("carrier did not toggle at half period");
endmodule

//--- iopc_top.sv
`timescale 1ns/1ps
`include "iopc_defs.svh"
// Behaviour
// - one 16-bit bidirectional port and one 8-bit input-only port.
// - per-pin direction register selects output drive or input for the bidir port.
// - per-pin pull-up enable for every input-only pin and for each bidir pin set as input.
// - any pin change on either port wakes from stop and watch modes.
// - highest bidir pin can be modulated by about 38.5 kHz carrier.
// - four lowest bidir pins are external interrupt sources while set as inputs.
module iopc_top (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // software controls
  input  wire iopc_pkg::iopc_bidir_t  dir_wdata,
  input  wire logic                 dir_we,
  input  wire iopc_pkg::iopc_bidir_t  out_wdata,
  input  wire logic                 out_we,
  input  wire iopc_pkg::iopc_bidir_t  pu_bidir_wdata,
  input  wire iopc_pkg::iopc_inonly_t pu_in_wdata,
  input  wire logic                 pu_we,
  input  wire logic                 ir_mod_en,
  input  wire logic                 stop_mode,
  input  wire logic                 watch_mode,
  // bidirectional pins
  input  wire iopc_pkg::iopc_bidir_t  bidir_port_pins_i,
  output iopc_pkg::iopc_bidir_t       bidir_port_pins_o,
  output iopc_pkg::iopc_bidir_t       bidir_port_pins_oe,
  output iopc_pkg::iopc_bidir_t       bidir_pullup_en,
  // input-only pins
  input  wire iopc_pkg::iopc_inonly_t input_only_port_pins,
  output iopc_pkg::iopc_inonly_t      input_only_pullup_en,
  // status to core
  output iopc_pkg::iopc_bidir_t       bidir_rdata,
  output iopc_pkg::iopc_inonly_t      inonly_rdata,
  output iopc_pkg::iopc_bidir_t       dir_rdata,
  output iopc_pkg::iopc_bidir_t       out_rdata,
  output logic                      wake_req,
  output iopc_pkg::iopc_irq_t         ext_irq
);
  import iopc_pkg::*;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  iopc_bidir_t  dir_r, dir_nxt;
  iopc_bidir_t  out_r, out_nxt;
  iopc_bidir_t  pub_r, pub_nxt;
  iopc_inonly_t pui_r, pui_nxt;
  iopc_bidir_t  pbo_r, pbo_nxt;

  always_comb begin
    dir_nxt = dir_we ? dir_wdata : dir_r;
    out_nxt = out_we ? out_wdata : out_r;
    pub_nxt = pu_we ? pu_bidir_wdata : pub_r;
    pui_nxt = pu_we ? pu_in_wdata : pui_r;
    // pull-up never fights a driven output
    pbo_nxt = pub_nxt & ~dir_nxt;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_r <= `IOPC_DIR_RST;
      out_r <= `IOPC_OUT_RST;
      pub_r <= `IOPC_PU_BIDIR_RST;
      pui_r <= `IOPC_PU_IN_RST;
      pbo_r <= `IOPC_PU_BIDIR_RST;
    end else begin
      dir_r <= dir_nxt;
      out_r <= out_nxt;
      pub_r <= pub_nxt;
      pui_r <= pui_nxt;
      pbo_r <= pbo_nxt;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  iopc_bidir_t  bsy1_r, bsy2_r, bprev_r;
  iopc_inonly_t isy1_r, isy2_r, iprev_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bsy1_r  <= '0;
      bsy2_r  <= '0;
      bprev_r <= '0;
      isy1_r  <= '0;
      isy2_r  <= '0;
      iprev_r <= '0;
    end else begin
      bsy1_r  <= bidir_port_pins_i;
      bsy2_r  <= bsy1_r;
      bprev_r <= bsy2_r;
      isy1_r  <= input_only_port_pins;
      isy2_r  <= isy1_r;
      iprev_r <= isy2_r;
    end
  end

  // ----------------------------------------
  // edge detect priming
  // ----------------------------------------
  // chain holds reset zeros for a few edges; a pin idling high
  // would otherwise look like an edge right after reset
  logic [1:0] prime_r;
  logic [1:0] prime_nxt;
  logic       edges_ok;

  always_comb begin
    prime_nxt = prime_r;
    if (prime_r != `IOPC_SYNC_FILL) begin
      prime_nxt = prime_r + 2'h1;
    end
    edges_ok = (prime_r == `IOPC_SYNC_FILL);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prime_r <= 2'h0;
    end else begin
      prime_r <= prime_nxt;
    end
  end

  // ----------------------------------------
  // IR carrier
  // ----------------------------------------
  iopc_car_if car ();
  assign car.enable = ir_mod_en;

  iopc_carrier u_car (
    .mclk (mclk),
    .nrst (nrst),
    .car  (car.gen)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  iopc_bidir_t  pin_o_nxt;
  iopc_bidir_t  bchg;
  logic         ichg;
  logic         wake_nxt;
  logic         wake_r;
  iopc_irq_t    irq_nxt;
  iopc_irq_t    irq_r;
  iopc_bidir_t  pin_o_r;

  always_comb begin
    pin_o_nxt = out_r;
    // modulated pin is data AND carrier; plain data otherwise
    pin_o_nxt[`IOPC_IR_BIT] = ir_mod_en ? (out_r[`IOPC_IR_BIT] & car.carrier)
                                        : out_r[`IOPC_IR_BIT];
    // edges only count once the chain holds real pin samples
    bchg     = edges_ok ? (bsy2_r ^ bprev_r) : '0;
    ichg     = edges_ok && (|(isy2_r ^ iprev_r));
    // any edge on either port wakes; only meaningful while sleeping
    wake_nxt = (stop_mode || watch_mode) && ((|bchg) || ichg);
    // edge pulse per external source, inputs only
    irq_nxt  = bchg[`IOPC_EXT_IRQ_N-1:0] & ~dir_r[`IOPC_EXT_IRQ_N-1:0];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_o_r <= `IOPC_OUT_RST;
      wake_r  <= 1'b0;
      irq_r   <= '0;
    end else begin
      pin_o_r <= pin_o_nxt;
      wake_r  <= wake_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign bidir_port_pins_o    = pin_o_r;
  assign bidir_port_pins_oe   = dir_r;
  assign bidir_pullup_en      = pbo_r;
  assign input_only_pullup_en = pui_r;
  assign bidir_rdata          = bsy2_r;
  assign inonly_rdata         = isy2_r;
  assign dir_rdata            = dir_r;
  assign out_rdata            = out_r;
  assign wake_req             = wake_r;
  assign ext_irq              = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  dir_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    dir_we |=> bidir_port_pins_oe == $past(dir_wdata))
    else $error("direction write not applied");

  pu_write_a: assert property (@(posedge mclk) disable iff (!nrst)
    pu_we |=> input_only_pullup_en == $past(pu_in_wdata))
    else $error("pull-up write not applied");

  pin_wake_a: assert property (@(posedge mclk) disable iff (!nrst)
    ((stop_mode || watch_mode) && $changed(input_only_port_pins))
      ##1 (stop_mode || watch_mode) ##1 ((stop_mode || watch_mode) && edges_ok)
      |-> ##1 wake_req)
    else $error("input pin change did not wake");

  wake_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    !$past(stop_mode) && !$past(watch_mode) |-> !wake_req)
    else $error("wake raised while awake");

  ext_irq_a: assert property (@(posedge mclk) disable iff (!nrst)
    (edges_ok && dir_r[0] == 1'b0 && bsy2_r[0] != bprev_r[0]) |=> ext_irq[0])
    else $error("external interrupt edge missed");

  ir_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    !ir_mod_en |=> bidir_port_pins_o[15] == $past(out_r[15]))
    else $error("unmodulated ir pin differs from data");

  ir_and_a: assert property (@(posedge mclk) disable iff (!nrst)
    ir_mod_en |=> bidir_port_pins_o[15] == ($past(out_r[15]) & $past(car.carrier)))
    else $error("modulated ir pin not data and carrier");

  out_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    out_we |=> ##1 bidir_port_pins_o[14:0] == $past(out_wdata[14:0], 2))
    else $error("port data not driven");

  pu_bidir_a: assert property (@(posedge mclk) disable iff (!nrst)
    pu_we |=> bidir_pullup_en == ($past(pu_bidir_wdata) & ~bidir_port_pins_oe))
    else $error("port pull-up write not applied");

  irq_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
    (ext_irq & $past(dir_r[`IOPC_EXT_IRQ_N-1:0])) == '0)
    else $error("interrupt from an output pin");

  prime_quiet_a: assert property (@(posedge mclk) disable iff (!nrst)
    prime_r != `IOPC_SYNC_FILL |=> !wake_req && ext_irq == '0)
    else $error("edge reported before sync chain filled");
endmodule

//--- iopc_board.sv
`timescale 1ns/1ps
module iopc_board (
  // clock
  input  wire logic                  mclk,
  // device side of the bidir pins
  input  wire iopc_pkg::iopc_bidir_t pin_o,
  input  wire iopc_pkg::iopc_bidir_t pin_oe,
  input  wire iopc_pkg::iopc_bidir_t pin_pu,
  // buttons on the board
  input  wire iopc_pkg::iopc_bidir_t btn_en,
  input  wire iopc_pkg::iopc_bidir_t btn_lvl,
  // resolved wire level
  output iopc_pkg::iopc_bidir_t      pin_lvl
);
  import iopc_pkg::*;
  iopc_bidir_t last_r;
  // a floating line shows the inverse of the last level put on it, never a stale copy
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i] || btn_en[i] || pin_pu[i]) last_r[i] <= pin_lvl[i];
    end
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pin_oe[i]) pin_lvl[i] = pin_o[i];
      else if (btn_en[i]) pin_lvl[i] = btn_lvl[i];
      else if (pin_pu[i]) pin_lvl[i] = 1'b1;
      else pin_lvl[i] = ~last_r[i];
    end
  end
endmodule

//--- iopc_top_tb.sv
`timescale 1ns/1ps
module iopc_top_tb;
  import iopc_pkg::*;
  logic         mclk, nrst, dir_we, out_we, pu_we, ir_mod_en, stop_mode, watch_mode, wake_req;
  iopc_bidir_t  dir_wdata, out_wdata, pu_bidir_wdata, btn_en, btn_lvl, pin_lvl;
  iopc_bidir_t  pin_o, pin_oe, pin_pu, bidir_rdata, dir_rdata, out_rdata;
  iopc_inonly_t pu_in_wdata, in_pins, in_pu, inonly_rdata;
  iopc_irq_t    ext_irq, q;
  int           fail_count, checks_done, n;
  iopc_top DUT (.mclk(mclk), .nrst(nrst), .dir_wdata(dir_wdata), .dir_we(dir_we),
    .out_wdata(out_wdata), .out_we(out_we), .pu_bidir_wdata(pu_bidir_wdata),
    .pu_in_wdata(pu_in_wdata), .pu_we(pu_we), .ir_mod_en(ir_mod_en), .stop_mode(stop_mode),
    .watch_mode(watch_mode), .bidir_port_pins_i(pin_lvl), .bidir_port_pins_o(pin_o),
    .bidir_port_pins_oe(pin_oe), .bidir_pullup_en(pin_pu), .input_only_port_pins(in_pins),
    .input_only_pullup_en(in_pu), .bidir_rdata(bidir_rdata), .inonly_rdata(inonly_rdata),
    .dir_rdata(dir_rdata), .out_rdata(out_rdata), .wake_req(wake_req), .ext_irq(ext_irq));
  iopc_board board (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
    .btn_en(btn_en), .btn_lvl(btn_lvl), .pin_lvl(pin_lvl));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write strobe set {dir, out, pu}; data goes to every field
  task automatic wr(logic [2:0] we, iopc_bidir_t v);
    @(posedge mclk);
    dir_wdata      <= v;
    out_wdata      <= v;
    pu_bidir_wdata <= v;
    pu_in_wdata    <= v[7:0];
    {dir_we, out_we, pu_we} <= we;
    @(posedge mclk);
    {dir_we, out_we, pu_we} <= 3'b000;
    #1;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  // cycles until pin 15 changes, at most 600
  task automatic span(output int c);
    logic s;
    c = 0;
    s = pin_o[15];
    while (pin_o[15] === s && c < 600) begin
      tick(1);
      c++;
    end
  endtask
  // edge index of the first wake pulse, and all irq pulses, over 8 edges
  task automatic ev(output int at_w, output iopc_irq_t qq);
    at_w = 0;
    qq   = '0;
    for (int i = 1; i <= 8; i++) begin
      tick(1);
      if (wake_req === 1'b1 && at_w == 0) at_w = i;
      qq = qq | ext_irq;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // tests take under 2000 cycles
  initial begin
    #500000;
    fail_count++;
    give_verdict();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {nrst, dir_we, out_we, pu_we, ir_mod_en, stop_mode, watch_mode} = '0;
    {dir_wdata, out_wdata, pu_bidir_wdata, btn_lvl} = '0;
    {pu_in_wdata, in_pins} = '0;
    btn_en = 16'hFFFF;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    tick(1);
    chk("oe", pin_oe, 16'h0000);
    chk("pullup", pin_pu, 16'h0000);
    $display("test reset done");
    wr(3'b001, 16'h00FF);
    chk("pullup", pin_pu, 16'h00FF);
    chk("in pullup", in_pu, 8'hFF);
    wr(3'b100, 16'hF00F);
    chk("oe", pin_oe, 16'hF00F);
    chk("dir rb", dir_rdata, 16'hF00F);
    chk("pullup", pin_pu, 16'h00F0);
    wr(3'b010, 16'hA5A5);
    chk("out rb", out_rdata, 16'hA5A5);
    tick(1);
    chk("pin out", pin_o, 16'hA5A5);
    @(posedge mclk);
    in_pins <= 8'h5A;
    tick(3);
    chk("bidir rd", bidir_rdata, 16'hA005);
    chk("in rd", inonly_rdata, 8'h5A);
    $display("test direction done");
    @(posedge mclk);
    ir_mod_en <= 1'b1;
    tick(1);
    span(n);
    span(n);
    chk("half period", 16'(n), 16'h0103);
    wr(3'b010, 16'h0000);
    tick(1);
    span(n);
    chk("gated low", 16'(n), 16'h0258);
    @(posedge mclk);
    ir_mod_en <= 1'b0;
    $display("test carrier done");
    wr(3'b100, 16'h0000);
    @(posedge mclk);
    stop_mode <= 1'b1;
    tick(4);
    @(posedge mclk);
    btn_lvl <= 16'h0001;
    ev(n, q);
    chk("stop wake", 16'(n), 16'h0003);
    chk("irq", q, 4'h1);
    @(posedge mclk);
    stop_mode  <= 1'b0;
    watch_mode <= 1'b1;
    @(posedge mclk);
    in_pins <= 8'hDA;
    ev(n, q);
    chk("watch wake", 16'(n), 16'h0003);
    chk("irq", q, 4'h0);
    @(posedge mclk);
    watch_mode <= 1'b0;
    @(posedge mclk);
    btn_lvl <= 16'h0003;
    ev(n, q);
    chk("awake", 16'(n), 16'h0000);
    chk("irq", q, 4'h2);
    wr(3'b100, 16'h0004);
    wr(3'b010, 16'h0004);
    ev(n, q);
    chk("out irq", q, 4'h0);
    $display("test wake done");
    wr(3'b001, 16'h0010);
    chk("pullup", pin_pu, 16'h0010);
    chk("in pullup", in_pu, 8'h10);
    @(posedge mclk);
    btn_en <= 16'hFFEF;
    tick(3);
    chk("pulled pin", bidir_rdata, 16'h0017);
    wr(3'b001, 16'h0000);
    tick(3);
    chk("floating pin", bidir_rdata, 16'h0007);
    @(posedge mclk);
    btn_en <= 16'hFFFF;
    $display("test pull-up done");
    @(posedge mclk);
    nrst <= 1'b0;
    tick(2);
    chk("rst dir", dir_rdata, 16'h0000);
    chk("rst out", pin_o, 16'h0000);
    @(posedge mclk);
    nrst <= 1'b1;
    ev(n, q);
    chk("rst irq", q, 4'h0);
    chk("rst pins", bidir_rdata, 16'h0003);
    $display("test second reset done");
    give_verdict();
  end
endmodule
